// file: rtl/ctblr_pkg.sv
// Purpose: Constants and carrier types for the critical-temperature register bank.
// Assumes: One byte-wide register port driven by an external two-wire protocol engine.
// Notes: Register storage is addressed by index; the offset table maps indices to addresses.
package ctblr_pkg;

  localparam int NREG = 43;
  localparam int NCH = 3;
  localparam int HYS_W = 4;

  // Register index of each register that the logic itself reads.
  localparam int IDX_PRI = 1;
  localparam int IDX_SEC = 2;
  localparam int IDX_QUAT = 4;
  localparam int IDX_HYS = 24;
  localparam int IDX_CRIT [NCH] = '{13, 16, 19};

  localparam logic [7:0] OFS [NREG] = '{
    8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
    8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13,
    8'h16, 8'h17, 8'h18, 8'h19, 8'h1A,
    8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29,
    8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h33};

  localparam logic [7:0] RST [NREG] = '{
    8'h20, 8'h01, 8'h84, 8'h44, 8'h00, 8'h07, 8'h01, 8'h09, 8'h52, 8'h18, 8'h00,
    8'h8B, 8'h54, 8'h95, 8'h8B, 8'h54, 8'h95, 8'h8B, 8'h54, 8'h95,
    8'h00, 8'h00, 8'h00, 8'hFF, 8'h05,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  // Bits that storage keeps; reserved bits read as zero, and the lock and reset bits read from their own flops.
  localparam logic [7:0] WMASK [NREG] = '{
    8'hFF, 8'hBF, 8'hBE, 8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'hCF, 8'hFF, 8'h1C, 8'hE0,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  localparam logic LOCKABLE [NREG] = '{
    1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0,
    1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1,
    1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
    1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
    1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  // Field positions.
  localparam int BIT_SRC = 7;
  localparam int BIT_LOCK = 6;
  localparam int BIT_CYCLE = 7;
  localparam int BIT_CSEL_HI = 5;
  localparam int BIT_CSEL_LO = 4;
  localparam int BIT_SUPPRESS = 1;
  localparam int BIT_SWRST = 0;
  localparam int BIT_XOR = 3;

  localparam logic [7:0] HYS_RST = 8'h05;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ctblr_req_type;

endpackage

// file: rtl/ctblr_regs.sv
// Purpose: Register bank, critical-temperature fan boost, write lock, software reset and board test chain.
// Assumes: Measured temperatures arrive as 8-bit codes in the same format as the limit registers.
// Notes: The lock is cleared only by rst_i, which stands for power-on reset.
`timescale 1ns/10ps
module ctblr_regs #(
  parameter int XOR_W = 8
) (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register port from the protocol engine.
  input wire ctblr_pkg::ctblr_req_type req_i,
  output logic [7:0] rdata_o,
  output logic ack_o,
  // Measured temperatures, channel 0 local, 1 and 2 remote.
  input wire logic [ctblr_pkg::NCH-1:0][7:0] temp_i,
  // Board test chain pins.
  input wire logic [XOR_W-1:0] xor_pins_i,
  output logic xor_out_o,
  // Policy outputs to the fan and conversion logic.
  output logic full_speed_o,
  output logic [ctblr_pkg::NCH-1:0] crit_status_o,
  output logic speed_control_source_o,
  output logic multi_channel_cycle_o,
  output logic [1:0] chan_sel_o,
  output logic table_size_select_o,
  output logic lock_o
);

  if (XOR_W < 1) begin : g_bad_width
    $error("XOR_W must be at least one");
  end

  logic [7:0] regs_ff [ctblr_pkg::NREG];
  logic [7:0] view [ctblr_pkg::NREG];
  logic lock_ff;
  logic swrst_ff;
  logic [ctblr_pkg::NCH-1:0] crit_ff;
  logic full_speed_ff;
  logic [7:0] rdata_ff;
  logic ack_ff;
  logic xor_out_ff;
  logic [7:0] nxt_rdata;
  logic [ctblr_pkg::NCH-1:0] trip;
  logic [ctblr_pkg::NCH-1:0] release_ok;
  logic [ctblr_pkg::HYS_W-1:0] hyst;
  logic suppress;
  logic sec_write;
  logic pri_write;

  assign suppress = regs_ff[ctblr_pkg::IDX_SEC][ctblr_pkg::BIT_SUPPRESS];
  assign hyst = regs_ff[ctblr_pkg::IDX_HYS][ctblr_pkg::HYS_W-1:0];
  assign pri_write = req_i.wr && (req_i.addr == ctblr_pkg::OFS[ctblr_pkg::IDX_PRI]) && !lock_ff;
  assign sec_write = req_i.wr && (req_i.addr == ctblr_pkg::OFS[ctblr_pkg::IDX_SEC]) && !lock_ff;

  // Register storage, one entry per index.
  for (genvar i = 0; i < ctblr_pkg::NREG; i++) begin : g_reg
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        regs_ff[i] <= ctblr_pkg::RST[i];
      end else if (ce_i) begin
        if (swrst_ff) begin
          regs_ff[i] <= ctblr_pkg::RST[i];
        end else if (req_i.wr && req_i.addr == ctblr_pkg::OFS[i] && !(ctblr_pkg::LOCKABLE[i] && lock_ff)) begin
          regs_ff[i] <= req_i.wdata & ctblr_pkg::WMASK[i];
        end
      end
    end

    // Lock and reset bits are kept outside storage so that software reset cannot touch the lock.
    always_comb begin
      view[i] = regs_ff[i];
      if (i == ctblr_pkg::IDX_PRI) begin
        view[i][ctblr_pkg::BIT_LOCK] = lock_ff;
      end
      if (i == ctblr_pkg::IDX_SEC) begin
        view[i][ctblr_pkg::BIT_SWRST] = swrst_ff;
      end
    end
  end

  // The lock is sticky; only power-on reset clears it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_ff <= 1'b0;
    end else if (ce_i && pri_write && req_i.wdata[ctblr_pkg::BIT_LOCK]) begin
      lock_ff <= 1'b1;
    end
  end

  // Software reset acts one cycle after the write and then clears itself.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      swrst_ff <= 1'b0;
    end else if (ce_i) begin
      if (swrst_ff) begin
        swrst_ff <= 1'b0;
      end else if (sec_write && req_i.wdata[ctblr_pkg::BIT_SWRST]) begin
        swrst_ff <= 1'b1;
      end
    end
  end

  // Read data path; unmapped addresses read as zero and every access is acknowledged.
  always_comb begin
    nxt_rdata = ctblr_pkg::UNMAPPED_DATA;
    for (int k = 0; k < ctblr_pkg::NREG; k++) begin
      if (req_i.addr == ctblr_pkg::OFS[k]) begin
        nxt_rdata = view[k];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= req_i.wr || req_i.rd;
      if (req_i.rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // Per-channel critical comparison with shared hysteresis.
  for (genvar c = 0; c < ctblr_pkg::NCH; c++) begin : g_ch
    logic [7:0] limit;
    logic [8:0] floor_v;
    assign limit = regs_ff[ctblr_pkg::IDX_CRIT[c]];
    // A limit below the hysteresis gives a negative floor, which no code can go under.
    assign floor_v = {1'b0, limit} - {5'h00, hyst};
    assign trip[c] = temp_i[c] > limit;
    assign release_ok[c] = !floor_v[8] && (temp_i[c] < floor_v[7:0]);

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        crit_ff[c] <= 1'b0;
      end else if (ce_i) begin
        if (trip[c]) begin
          crit_ff[c] <= 1'b1;
        end else if (release_ok[c]) begin
          crit_ff[c] <= 1'b0;
        end
      end
    end

    chk_crit_trip_set: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && (temp_i[c] > regs_ff[ctblr_pkg::IDX_CRIT[c]]) |=> crit_ff[c])
      else $error("Channel above its critical limit did not latch");

    chk_crit_hold_band: assert property (@(posedge clk_i) disable iff (rst_i)
      crit_ff[c] && !(ce_i && release_ok[c]) |=> crit_ff[c])
      else $error("Critical latch released above the hysteresis floor");
  end

  // Any latched channel forces full speed unless suppressed.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full_speed_ff <= 1'b0;
    end else if (ce_i) begin
      full_speed_ff <= (|crit_ff) && !suppress;
    end
  end

  // Board test chain; it reads zero when the test mode is off.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xor_out_ff <= 1'b0;
    end else if (ce_i) begin
      xor_out_ff <= regs_ff[ctblr_pkg::IDX_QUAT][ctblr_pkg::BIT_XOR] && (^xor_pins_i);
    end
  end

  assign rdata_o = rdata_ff;
  assign ack_o = ack_ff;
  assign xor_out_o = xor_out_ff;
  assign full_speed_o = full_speed_ff;
  assign crit_status_o = crit_ff;
  assign lock_o = lock_ff;
  assign speed_control_source_o = regs_ff[ctblr_pkg::IDX_PRI][ctblr_pkg::BIT_SRC];
  assign multi_channel_cycle_o = regs_ff[ctblr_pkg::IDX_SEC][ctblr_pkg::BIT_CYCLE];
  assign chan_sel_o = regs_ff[ctblr_pkg::IDX_SEC][ctblr_pkg::BIT_CSEL_HI:ctblr_pkg::BIT_CSEL_LO];
  assign table_size_select_o = regs_ff[ctblr_pkg::IDX_SEC][3];

  chk_full_speed_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && (|crit_ff) && !suppress |=> full_speed_o)
    else $error("Latched critical channel did not force full speed");

  chk_suppress_blocks_boost: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && suppress |=> !full_speed_o)
    else $error("Full speed forced while suppress bit set");

  chk_hyst_after_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> regs_ff[ctblr_pkg::IDX_HYS] == ctblr_pkg::HYS_RST)
    else $error("Hysteresis not five degrees after reset");

  chk_hyst_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    regs_ff[ctblr_pkg::IDX_HYS][7:ctblr_pkg::HYS_W] == 4'h0)
    else $error("Reserved hysteresis bits not zero");

  chk_lock_persist: assert property (@(posedge clk_i) disable iff (rst_i)
    lock_ff |=> lock_ff [*8])
    else $error("Write lock was released");

  chk_locked_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && lock_ff && !swrst_ff && req_i.wr && req_i.addr == ctblr_pkg::OFS[ctblr_pkg::IDX_HYS]
    |=> $stable(regs_ff[ctblr_pkg::IDX_HYS]) && ack_o)
    else $error("Locked register changed or write not acknowledged");

  chk_swrst_restores: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && swrst_ff |=> regs_ff[ctblr_pkg::IDX_SEC] == ctblr_pkg::RST[ctblr_pkg::IDX_SEC]
      && regs_ff[ctblr_pkg::IDX_HYS] == ctblr_pkg::HYS_RST && !swrst_ff)
    else $error("Software reset did not restore defaults or clear itself");

  chk_xor_chain_out: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && regs_ff[ctblr_pkg::IDX_QUAT][ctblr_pkg::BIT_XOR] |=> xor_out_o == $past(^xor_pins_i))
    else $error("Test chain output does not match pin parity");

endmodule

// file: tb/ctblr_host.sv
// Purpose: Host model that drives the byte-wide register request port of the bank.
// Assumes: Each access is answered at the edge that takes it, so the next falling edge sees the answer.
// Notes: The request changes only on falling edges, so every rising edge sees it stable.
`timescale 1ns/10ps
module ctblr_host (
  // Clock.
  input wire logic clk_i,
  // Answer from the bank.
  input wire logic ack_i,
  input wire logic [7:0] rdata_i,
  // Request to the bank.
  output ctblr_pkg::ctblr_req_type req_o
);
  initial begin
    req_o = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
                      output logic k);
    @(negedge clk_i);
    req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk_i);
    q = rdata_i;
    k = ack_i;
    // Idle fields are inverted so that a stale address can never pass for a held one.
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// file: tb/tb_ctblr_regs.sv
// Purpose: Self-checking bench for the critical-temperature register bank.
// Assumes: Inputs change on falling edges; outputs are sampled on falling edges.
// Notes: Reset stands for power-on, the only clear of the write lock.
`timescale 1ns/10ps
module tb_ctblr_regs;
  logic clk_i;
  logic rst_i;
  logic ce_i;
  ctblr_pkg::ctblr_req_type req;
  logic [7:0] rdata;
  logic ack;
  logic [ctblr_pkg::NCH-1:0][7:0] temp;
  logic [7:0] pins;
  logic xor_out, full_speed, scs, mcc, tss, lock;
  logic [ctblr_pkg::NCH-1:0] crit;
  logic [1:0] csel;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] q;
  logic k;
  logic [7:0] def_a [6] = '{8'h01, 8'h02, 8'h0D, 8'h10, 8'h13, 8'h1A};
  logic [7:0] def_v [6] = '{8'h01, 8'h84, 8'h95, 8'h95, 8'h95, 8'h05};

  ctblr_host host_u (.clk_i(clk_i), .ack_i(ack), .rdata_i(rdata), .req_o(req));
  ctblr_regs #(.XOR_W(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req), .rdata_o(rdata),
    .ack_o(ack), .temp_i(temp), .xor_pins_i(pins), .xor_out_o(xor_out), .full_speed_o(full_speed),
    .crit_status_o(crit), .speed_control_source_o(scs), .multi_channel_cycle_o(mcc), .chan_sel_o(csel),
    .table_size_select_o(tss), .lock_o(lock));

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, d, q, k);
    check("write ack", {7'h00, k}, 8'h01);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host_u.xfer(1'b0, a, 8'h00, q, k);
    check("read data", q, exp);
  endtask
  task automatic settle();
    repeat (3) @(negedge clk_i);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // The whole sequence needs well under a thousand cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    temp = '0;
    pins = 8'h00;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    check("cycle mode", {7'h00, mcc}, 8'h01);
    check("speed source", {7'h00, scs}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      rd(def_a[i], def_v[i]);
    end
    wr(8'h1A, 8'hFF);
    rd(8'h1A, 8'h0F);
    wr(8'h1A, 8'h02);
    for (int c = 0; c < 3; c++) begin
      wr(def_a[c + 2], 8'hA0);
    end
    // A low enable must freeze the latches even with channel 0 above its limit.
    ce_i = 1'b0;
    temp[0] = 8'hA1;
    settle();
    check("frozen latch", {5'h00, crit}, 8'h00);
    temp[0] = 8'h00;
    ce_i = 1'b1;
    for (int c = 0; c < 3; c++) begin
      temp[c] = 8'hA1;
      settle();
      check("crit latch", {5'h00, crit}, 8'h01 << c);
      check("full speed", {7'h00, full_speed}, 8'h01);
      temp[c] = 8'h9E;
      settle();
      check("held latch", {5'h00, crit}, 8'h01 << c);
      temp[c] = 8'h9D;
      settle();
      check("released", {6'h00, full_speed, crit[c]}, 8'h00);
    end
    wr(8'h02, 8'h86);
    temp[0] = 8'hA1;
    settle();
    check("suppressed", {6'h00, full_speed, crit[0]}, 8'h01);
    wr(8'h02, 8'h3C);
    settle();
    check("unsuppressed", {6'h00, full_speed, mcc}, 8'h02);
    check("channel select", {5'h00, tss, csel}, 8'h07);
    temp[0] = 8'h00;
    wr(8'h01, 8'h81);
    check("table source", {7'h00, scs}, 8'h01);
    pins = 8'h07;
    settle();
    check("chain off", {7'h00, xor_out}, 8'h00);
    wr(8'h04, 8'h08);
    settle();
    check("chain odd", {7'h00, xor_out}, 8'h01);
    pins = 8'h03;
    settle();
    check("chain even", {7'h00, xor_out}, 8'h00);
    wr(8'h1A, 8'h0C);
    wr(8'h02, 8'h01);
    rd(8'h02, 8'h84);
    rd(8'h1A, 8'h05);
    rd(8'h01, 8'h01);
    wr(8'h01, 8'h41);
    check("lock", {7'h00, lock}, 8'h01);
    wr(8'h1A, 8'h0C);
    rd(8'h1A, 8'h05);
    wr(8'h08, 8'h33);
    rd(8'h08, 8'h33);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h01);
    check("lock kept", {7'h00, lock}, 8'h01);
    rd(8'h01, 8'h41);
    close_out();
  end
endmodule
